//--- rtl/sdlo_cfg.svh
/*
 * Constants of the serial converter front end: word layout, codes and timing counts.
 * Assumes a system clock of 250 MHz; included by the package and the top module.
 */
`ifndef SDLO_CFG_SVH
`define SDLO_CFG_SVH

`define SDLO_WORD_W 24
`define SDLO_CODE_W 16
`define SDLO_ADDR_W 8
`define SDLO_ADDR_DATA 8'h01
`define SDLO_ADDR_READ 8'h02
`define SDLO_ADDR_CTRL 8'h55
`define SDLO_CTRL_DCEN_BIT 3
`define SDLO_READ_SEL_LSB 0
`define SDLO_CODE_ZERO 16'h0000
`define SDLO_CODE_MID 16'h8000
`define SDLO_CLK_PERIOD_NS 4
`define SDLO_CTRL_HOLD_US 5
`define SDLO_CTRL_HOLD_CYC ((`SDLO_CTRL_HOLD_US * 1000 + `SDLO_CLK_PERIOD_NS - 1) / `SDLO_CLK_PERIOD_NS)

`endif

//--- rtl/sdlo_pkg.sv
/*
 * Types of the serial converter front end.
 * Assumes sdlo_cfg.svh is on the include path.
 */
`include "sdlo_cfg.svh"

package sdlo_pkg;

  typedef logic [`SDLO_WORD_W-1:0] sdlo_word_t;
  typedef logic [`SDLO_CODE_W-1:0] sdlo_code_t;

  // Serial output modes.
  typedef enum logic [2:0] {
    SDLO_OUT_OFF   = 3'b001,
    SDLO_OUT_READ  = 3'b010,
    SDLO_OUT_CHAIN = 3'b100
  } sdlo_out_t;

endpackage : sdlo_pkg

//--- rtl/sdlo_top.sv
/*
 * Serial front end of a single-channel converter: shift register, load strobe,
 * readback and daisy-chain output, override to a clear value and open-drain alarm.
 * Assumes the serial clock, data, strobe, override and alarm sources are asynchronous
 * to sys_clk and that the serial clock is well below a quarter of sys_clk.
 */
`timescale 1ns/1ns
`include "sdlo_cfg.svh"

module sdlo_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic serial_data_in,
  input wire logic load_strobe,
  input wire logic override,
  input wire logic clear_sel,
  input wire logic open_loop,
  input wire logic over_temp,
  input wire logic out_ready,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  output logic alarm_n_out,
  output logic alarm_n_oe,
  output logic [`SDLO_CODE_W-1:0] dac_code,
  output logic [`SDLO_ADDR_W-1:0] ctrl_word,
  output logic out_valid,
  output logic ctrl_busy
);

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.
  logic [6:0] meta_r;
  logic [6:0] sync_r;
  logic sclk_d_r;
  logic latch_d_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 7'h00;
      sync_r <= 7'h00;
      sclk_d_r <= 1'b0;
      latch_d_r <= 1'b0;
    end else begin
      meta_r <= {sclk, serial_data_in, load_strobe, override, clear_sel, open_loop, over_temp};
      sync_r <= meta_r;
      sclk_d_r <= sync_r[6];
      latch_d_r <= sync_r[4];
    end
  end

  logic sclk_s;
  logic serial_data_in_s;
  logic latch_s;
  logic ovr_s;
  logic csel_s;
  logic fault_s;
  logic sclk_rise;
  logic latch_rise;
  assign sclk_s = sync_r[6];
  assign serial_data_in_s = sync_r[5];
  assign latch_s = sync_r[4];
  assign ovr_s = sync_r[3];
  assign csel_s = sync_r[2];
  assign fault_s = sync_r[1] | sync_r[0];
  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign latch_rise = latch_s & ~latch_d_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Shift register, mode, load and serial output.
  sdlo_pkg::sdlo_word_t shift_r, shift_nxt;
  sdlo_pkg::sdlo_out_t mode_r, mode_nxt;
  logic chain_en_r, chain_en_nxt;
  logic sdo_r, sdo_nxt;
  logic sdo_oe_r, sdo_oe_nxt;
  logic ld_valid_r, ld_valid_nxt;
  sdlo_pkg::sdlo_word_t ld_word_r, ld_word_nxt;
  sdlo_pkg::sdlo_code_t code_r, code_nxt;
  logic [15:0] hold_cnt_r, hold_cnt_nxt;
  logic busy_r, busy_nxt;
  logic buf_in_ready;
  logic [`SDLO_ADDR_W-1:0] w_addr;
  assign w_addr = shift_r[`SDLO_WORD_W-1 -: `SDLO_ADDR_W];

  always_comb begin
    shift_nxt = shift_r;
    mode_nxt = mode_r;
    chain_en_nxt = chain_en_r;
    sdo_nxt = sdo_r;
    sdo_oe_nxt = sdo_oe_r;
    ld_valid_nxt = ld_valid_r;
    ld_word_nxt = ld_word_r;
    hold_cnt_nxt = hold_cnt_r;
    if (sclk_rise) begin
      // Shifting continues whatever the override does.
      shift_nxt = {shift_r[`SDLO_WORD_W-2:0], serial_data_in_s};
    end
    if (ld_valid_r && buf_in_ready) begin
      ld_valid_nxt = 1'b0;
    end
    if (sclk_d_r && !sclk_s && mode_r != sdlo_pkg::SDLO_OUT_OFF) begin
      // Change on the falling edge so the bit is settled at the next rising edge.
      sdo_nxt = shift_r[`SDLO_WORD_W-1];
    end
    if (latch_s && hold_cnt_r != 16'h0000) begin
      hold_cnt_nxt = hold_cnt_r - 16'h0001;
    end
    if (latch_rise) begin
      if (w_addr == `SDLO_ADDR_CTRL) begin
        chain_en_nxt = shift_r[`SDLO_CTRL_DCEN_BIT];
        hold_cnt_nxt = 16'(`SDLO_CTRL_HOLD_CYC);
      end
      if (w_addr == `SDLO_ADDR_READ) begin
        mode_nxt = sdlo_pkg::SDLO_OUT_READ;
        sdo_oe_nxt = 1'b1;
      end else begin
        // A new strobe ends any readback and releases the pin unless chaining is enabled.
        mode_nxt = chain_en_nxt ? sdlo_pkg::SDLO_OUT_CHAIN : sdlo_pkg::SDLO_OUT_OFF;
        sdo_oe_nxt = chain_en_nxt;
      end
      if (w_addr == `SDLO_ADDR_READ) begin
        case (shift_r[1:0])
          2'h0: shift_nxt = {`SDLO_ADDR_DATA, code_r};
          2'h1: shift_nxt = {`SDLO_ADDR_CTRL, 15'h0000, chain_en_r};
          default: shift_nxt = {`SDLO_ADDR_W'(0), 15'h0000, fault_s};
        endcase
      end
      ld_valid_nxt = 1'b1;
      ld_word_nxt = shift_r;
      // Present the first bit of the new content before the first rising edge.
      sdo_nxt = shift_nxt[`SDLO_WORD_W-1];
    end
    busy_nxt = (hold_cnt_nxt != 16'h0000);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= '0;
      mode_r <= sdlo_pkg::SDLO_OUT_OFF;
      chain_en_r <= 1'b0;
      sdo_r <= 1'b0;
      sdo_oe_r <= 1'b0;
      ld_valid_r <= 1'b0;
      ld_word_r <= '0;
      hold_cnt_r <= 16'h0000;
      busy_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      mode_r <= mode_nxt;
      chain_en_r <= chain_en_nxt;
      sdo_r <= sdo_nxt;
      sdo_oe_r <= sdo_oe_nxt;
      ld_valid_r <= ld_valid_nxt;
      ld_word_r <= ld_word_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      busy_r <= busy_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer between the load strobe and the converter register.
  sdlo_pkg::sdlo_word_t buf_r [2], buf_nxt [2];
  logic [1:0] cnt_r, cnt_nxt;
  logic rd_r, rd_nxt;
  logic wr_r, wr_nxt;
  logic buf_pop;
  assign buf_in_ready = (cnt_r != 2'h2);
  assign buf_pop = (cnt_r != 2'h0) && out_ready;

  always_comb begin
    buf_nxt = buf_r;
    cnt_nxt = cnt_r;
    rd_nxt = rd_r;
    wr_nxt = wr_r;
    if (ld_valid_r && buf_in_ready) begin
      buf_nxt[wr_r] = ld_word_r;
      wr_nxt = ~wr_r;
    end
    if (buf_pop) begin
      rd_nxt = ~rd_r;
    end
    cnt_nxt = cnt_r + 2'((ld_valid_r && buf_in_ready) ? 1 : 0) - 2'(buf_pop ? 1 : 0);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_r[0] <= '0;
      buf_r[1] <= '0;
      cnt_r <= 2'h0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
    end else begin
      buf_r <= buf_nxt;
      cnt_r <= cnt_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Converter register, override, alarm and outputs.
  sdlo_pkg::sdlo_code_t dac_r, dac_nxt;
  logic [`SDLO_ADDR_W-1:0] ctrl_r, ctrl_nxt;
  logic valid_r, valid_nxt;
  logic alarm_r, alarm_nxt;
  sdlo_pkg::sdlo_word_t head;
  assign head = buf_r[rd_r];

  always_comb begin
    code_nxt = code_r;
    ctrl_nxt = ctrl_r;
    valid_nxt = buf_pop;
    if (buf_pop && head[`SDLO_WORD_W-1 -: `SDLO_ADDR_W] == `SDLO_ADDR_DATA) begin
      code_nxt = head[`SDLO_CODE_W-1:0];
    end
    if (buf_pop && head[`SDLO_WORD_W-1 -: `SDLO_ADDR_W] == `SDLO_ADDR_CTRL) begin
      ctrl_nxt = head[`SDLO_ADDR_W-1:0];
    end
    if (ovr_s) begin
      dac_nxt = csel_s ? `SDLO_CODE_MID : `SDLO_CODE_ZERO;
    end else begin
      dac_nxt = code_nxt;
    end
    alarm_nxt = fault_s;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      code_r <= `SDLO_CODE_ZERO;
      dac_r <= `SDLO_CODE_ZERO;
      ctrl_r <= '0;
      valid_r <= 1'b0;
      alarm_r <= 1'b0;
    end else begin
      code_r <= code_nxt;
      dac_r <= dac_nxt;
      ctrl_r <= ctrl_nxt;
      valid_r <= valid_nxt;
      alarm_r <= alarm_nxt;
    end
  end

  // Open-drain alarm: output stays low, the enable pulls the pin.
  assign alarm_n_out = 1'b0;
  assign alarm_n_oe = alarm_r;
  assign serial_data_out = sdo_r;
  assign serial_data_out_oe = sdo_oe_r;
  assign dac_code = dac_r;
  assign ctrl_word = ctrl_r;
  assign out_valid = valid_r;
  assign ctrl_busy = busy_r;

endmodule : sdlo_top

//--- verif/sdlo_top_chk.sv
/* Port checker for sdlo_top, bound to every instance of it.
   Assumes sdlo_cfg.svh is on the include path. */
`timescale 1ns/1ns
`include "sdlo_cfg.svh"
module sdlo_top_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic override,
  input wire logic clear_sel,
  input wire logic open_loop,
  input wire logic over_temp,
  input wire logic out_ready,
  input wire logic alarm_n_out,
  input wire logic alarm_n_oe,
  input wire logic [`SDLO_CODE_W-1:0] dac_code,
  input wire logic out_valid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_alarm_set: assert property ((open_loop || over_temp)[*6] |-> alarm_n_oe)
    else $error("alarm not raised");
  a_alarm_clear: assert property ((!open_loop && !over_temp)[*6] |-> !alarm_n_oe)
    else $error("alarm without fault");
  a_alarm_pin: assert property (alarm_n_out == 1'b0)
    else $error("alarm pin driven high");
  a_clear_zero: assert property ((override && !clear_sel)[*6] |-> dac_code == 16'h0000)
    else $error("zero clear code wrong");
  a_clear_mid: assert property ((override && clear_sel)[*6] |-> dac_code == 16'h8000)
    else $error("midscale clear code wrong");
  a_code_load: assert property ((!override)[*6] ##0 $changed(dac_code) |-> out_valid)
    else $error("code changed without load");
  a_valid_pulse: assert property (out_valid [*3] |=> !out_valid)
    else $error("update burst too long");
  a_ready_gate: assert property (out_valid |-> $past(out_ready))
    else $error("update while stalled");
  c_mid: cover property (override && dac_code == 16'h8000);
  c_valid: cover property (out_valid);
  c_alarm: cover property (alarm_n_oe);
  c_burst: cover property (out_valid [*3]);
endmodule : sdlo_top_chk
bind sdlo_top sdlo_top_chk u_chk (.sys_clk, .rst_n, .override, .clear_sel, .open_loop,
  .over_temp, .out_ready, .alarm_n_out, .alarm_n_oe, .dac_code, .out_valid);

//--- verif/sdlo_host.sv
/* Host model: shifts 24-bit words MSB first on a 125 ns serial clock, then pulses the strobe.
   Assumes the device samples its inputs with its own clock. */
`timescale 1ns/1ns
module sdlo_host (
  output logic sclk,
  output logic serial_data_in,
  output logic load_strobe,
  input wire logic serial_data_out,
  output logic [23:0] rx
);
  initial begin
    sclk = 1'b0;
    serial_data_in = 1'b0;
    load_strobe = 1'b0;
    rx = 24'h0;
  end
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      serial_data_in = w[i];
      #62 sclk = 1'b1;
      rx = {rx[22:0], serial_data_out};
      #63 sclk = 1'b0;
    end
    serial_data_in = ~w[0];
    #50 load_strobe = 1'b1;
    #(w[23:16] == 8'h55 ? 5100 : 50) load_strobe = 1'b0;
    #50;
  endtask : send
endmodule : sdlo_host

//--- verif/serial_dac_load_override_alarm_tb.sv
/* Self-checking bench of sdlo_top with the host model on its serial side.
   Assumes the design and the checker are compiled first. */
`timescale 1ns/1ns
module serial_dac_load_override_alarm_tb;
  logic sys_clk, rst_n, sclk, serial_data_in, load_strobe, override, clear_sel;
  logic open_loop, over_temp, out_ready, serial_data_out, serial_data_out_oe;
  logic alarm_n_out, alarm_n_oe, out_valid, ctrl_busy, sdo_line;
  logic [15:0] dac_code;
  logic [7:0] ctrl_word;
  logic [23:0] host_rx;
  int n_fail = 0;
  int checks_done = 0;
  int n_valid = 0;
  // A released output line toggles so that no stale bit can be read.
  assign sdo_line = serial_data_out_oe ? serial_data_out : ~sys_clk;
  sdlo_top uut (.sys_clk, .rst_n, .sclk, .serial_data_in, .load_strobe, .override,
    .clear_sel, .open_loop, .over_temp, .out_ready, .serial_data_out, .serial_data_out_oe,
    .alarm_n_out, .alarm_n_oe, .dac_code, .ctrl_word, .out_valid, .ctrl_busy);
  sdlo_host u_host (.sclk, .serial_data_in, .load_strobe, .serial_data_out(sdo_line),
    .rx(host_rx));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (out_valid === 1'b1) n_valid++;
  end
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wait_clk
  task automatic t_load();
    wait_clk(1);
    out_ready = 1'b0;
    n_valid = 0;
    u_host.send(24'h011111);
    u_host.send(24'h012222);
    u_host.send(24'h013333);
    wait_clk(20);
    chk("stalled updates", 24'd0, 24'(n_valid));
    out_ready = 1'b1;
    wait_clk(20);
    chk("update count", 24'd3, 24'(n_valid));
    chk("loaded code", 24'h003333, {8'h00, dac_code});
    $display("test load done");
  endtask : t_load
  task automatic t_override();
    wait_clk(1);
    override = 1'b1;
    wait_clk(8);
    chk("zero clear", 24'h0, {8'h00, dac_code});
    clear_sel = 1'b1;
    wait_clk(8);
    chk("mid clear", 24'h008000, {8'h00, dac_code});
    u_host.send(24'h015a5a);
    wait_clk(8);
    chk("held clear", 24'h008000, {8'h00, dac_code});
    override = 1'b0;
    wait_clk(8);
    chk("code after clear", 24'h005a5a, {8'h00, dac_code});
    clear_sel = 1'b0;
    $display("test override done");
  endtask : t_override
  task automatic t_readback();
    u_host.send(24'h020000);
    wait_clk(4);
    chk("output enable", 24'h1, {23'h0, serial_data_out_oe});
    u_host.send(24'h000000);
    wait_clk(10);
    chk("read code", 24'h015a5a, host_rx);
    chk("released", 24'h0, {23'h0, serial_data_out_oe});
    $display("test readback done");
  endtask : t_readback
  task automatic t_alarm();
    wait_clk(1);
    over_temp = 1'b1;
    wait_clk(8);
    chk("heat alarm", 24'h1, {23'h0, alarm_n_oe});
    u_host.send(24'h020002);
    u_host.send(24'h000000);
    chk("read fault", 24'h000001, host_rx);
    over_temp = 1'b0;
    open_loop = 1'b1;
    wait_clk(8);
    chk("loop alarm", 24'h1, {23'h0, alarm_n_oe});
    open_loop = 1'b0;
    wait_clk(8);
    chk("alarm gone", 24'h0, {23'h0, alarm_n_oe});
    $display("test alarm done");
  endtask : t_alarm
  task automatic t_chain();
    fork
      u_host.send(24'h550008);
      begin
        #5000;
        chk("hold busy", 24'h1, {23'h0, ctrl_busy});
      end
    join
    wait_clk(20);
    chk("hold over", 24'h0, {23'h0, ctrl_busy});
    chk("control word", 24'h000008, {16'h0, ctrl_word});
    chk("chain enable", 24'h1, {23'h0, serial_data_out_oe});
    u_host.send(24'h01abcd);
    chk("chain out", 24'h550008, host_rx);
    wait_clk(20);
    chk("chain code", 24'h00abcd, {8'h00, dac_code});
    u_host.send(24'h020001);
    chk("chain out next", 24'h01abcd, host_rx);
    u_host.send(24'h000000);
    chk("read control", 24'h550001, host_rx);
    chk("still chained", 24'h1, {23'h0, serial_data_out_oe});
    rst_n = 1'b0;
    wait_clk(3);
    chk("reset code", 24'h0, {8'h00, dac_code});
    chk("reset enable", 24'h0, {23'h0, serial_data_out_oe});
    chk("reset control", 24'h0, {16'h0, ctrl_word});
    rst_n = 1'b1;
    wait_clk(2);
    u_host.send(24'h010102);
    wait_clk(20);
    chk("code after reset", 24'h000102, {8'h00, dac_code});
    chk("chain off", 24'h0, {23'h0, serial_data_out_oe});
    $display("test chain done");
  endtask : t_chain
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    override = 1'b0;
    clear_sel = 1'b0;
    open_loop = 1'b0;
    over_temp = 1'b0;
    out_ready = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    t_load();
    t_override();
    t_readback();
    t_alarm();
    t_chain();
    give_verdict();
  end
  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end
endmodule : serial_dac_load_override_alarm_tb
